// ===== logic/rfcfg_pkg.sv
// Constants and carriers for the RF configuration register slice.
// Assumes an 8-bit host register port on the core clock domain.
// Overview of operation
// - Load high preset byte at CRC start events.
// - High preset byte ignored in 8-bit CRC.
// - Selector 000 drives low, 001 high.
// - Codes 010/011 route encoder envelope, serial data.
// - Codes 100/101 route carrier, subcarrier demodulator.
// - Selector register reads zero after reset.
// - High alert when free space at or below level.
// - Low alert when fill at or below level.
// - Auto-reload restarts countdown from start value.
// - Without auto-reload stop at zero, flag expiry.
// - Timer ticks at clock over two to exponent.
// - Timer clock register reads 07h after reset.
// - FIFO level register resets to 08h.
// - Width bit set selects 8-bit CRC.
// - Start loads value; zero value never starts.
package rfcfg_pkg;
  localparam logic [5:0] ADDR_CRC_PRESET_HIGH  = 6'h24;
  localparam logic [5:0] ADDR_FIXED_PRESET_A   = 6'h25;
  localparam logic [5:0] ADDR_TEST_OUTPUT_SEL  = 6'h26;
  localparam logic [5:0] ADDR_FIXED_PRESET_B   = 6'h27;
  localparam logic [5:0] ADDR_FIFO_ALERT_LEVEL = 6'h29;
  localparam logic [5:0] ADDR_TIMER_CLOCK_DIV  = 6'h2A;
  localparam logic [7:0] RST_CRC_PRESET_HIGH   = 8'h63;
  localparam logic [7:0] RST_FIXED_PRESET_A    = 8'h00;
  localparam logic [7:0] RST_TEST_OUTPUT_SEL   = 8'h00;
  localparam logic [7:0] RST_FIFO_ALERT_LEVEL  = 8'h08;
  localparam logic [7:0] RST_TIMER_CLOCK_DIV   = 8'h07;
  localparam int         AUTO_RELOAD_BIT       = 5;
  localparam logic [4:0] DIV_EXP_MAX           = 5'h15;
  localparam logic [6:0] FIFO_DEPTH            = 7'h40;
  typedef enum logic [2:0] {
    RFCFG_SEL_LOW, RFCFG_SEL_HIGH, RFCFG_SEL_ENVELOPE, RFCFG_SEL_SERIAL,
    RFCFG_SEL_CARRIER, RFCFG_SEL_SUBCARRIER, RFCFG_SEL_RSVD6, RFCFG_SEL_RSVD7
  } rfcfg_sel_t;
  // Internal coder and demodulator taps offered to the test pin
  typedef struct packed {
    logic envelope;
    logic serialData;
    logic carrierDemod;
    logic subcarrierDemod;
  } rfcfg_taps_t;
  // Start and stop events from the CRC and timer engines
  typedef struct packed {
    logic crcStart;
    logic timerStart;
    logic timerStop;
  } rfcfg_events_t;
endpackage

// ===== logic/rfcfg_slice.sv
// Register slice: CRC preset high byte, test-output routing,
// FIFO alert level and timer clock divider with the countdown timer.
// Assumes register port and engine inputs are on core_clk.
`timescale 1ns/100ps
`default_nettype none
module rfcfg_slice (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   regWrEn,
  input  wire logic                   regRdEn,
  input  wire logic [5:0]             regAddr,
  input  wire logic [7:0]             regWrData,
  output logic      [7:0]             regRdData,
  input  wire rfcfg_pkg::rfcfg_taps_t   taps,
  input  wire rfcfg_pkg::rfcfg_events_t events,
  input  wire logic                   crcEnable,
  input  wire logic                   crcShortWidth,
  input  wire logic [7:0]             crcPresetLow,
  input  wire logic [7:0]             timerStartValue,
  input  wire logic [6:0]             fifoCount,
  output logic                        testOutputPin,
  output logic                        highFillAlert,
  output logic                        lowFillAlert,
  output logic      [15:0]            crcRegister,
  output logic                        timerRunning,
  output logic      [7:0]             timerValue,
  output logic                        timerExpiredFlag
);
  import rfcfg_pkg::*;

  // Free-running divider counter width, one bit past the largest exponent
  localparam int PRESCALE_W = 22;

  // An exponent past the counter width would still tick every 2^22 clocks, too fast
  if (int'(DIV_EXP_MAX) >= PRESCALE_W) begin : g_div_width_check
    $error("Prescaler counter too narrow for the largest exponent");
  end

  // ********************
  // State
  // ********************
  typedef struct packed {
    logic [7:0]            crcPresetHigh;
    logic [7:0]            fixedPresetA;
    logic [7:0]            testSel;
    logic [7:0]            fifo_alert_level;
    logic [7:0]            timerClk;
    logic [7:0]            rdData;
    logic [15:0]           crc;
    logic                  running;
    logic [7:0]            count;
    logic [PRESCALE_W-1:0] prescale;
    logic                  expired;
    logic                  pin;
    logic                  high_fill_alert;
    logic                  low_fill_alert;
  } rfcfg_state_t;

  rfcfg_state_t          state_ff;
  rfcfg_state_t          nxt_state;
  logic [PRESCALE_W-1:0] tickMask;
  logic                  tick;

  // 2^exp divider: tick when all low exp bits of the free counter are set
  always_comb begin
    tickMask = '0;
    for (int i = 0; i < PRESCALE_W; i++) begin
      if (i < int'(state_ff.timerClk[4:0])) begin
        tickMask[i] = 1'b1;
      end
    end
  end
  assign tick = ((state_ff.prescale & tickMask) == tickMask);

  always_comb begin
    nxt_state = state_ff;
    nxt_state.prescale = state_ff.prescale + PRESCALE_W'(1);

    // ********************
    // Register writes
    // ********************
    if (regWrEn) begin
      if (regAddr == ADDR_CRC_PRESET_HIGH) begin
        nxt_state.crcPresetHigh = regWrData;
      end else if (regAddr == ADDR_FIXED_PRESET_A) begin
        nxt_state.fixedPresetA = regWrData;
      end else if (regAddr == ADDR_TEST_OUTPUT_SEL) begin
        nxt_state.testSel = regWrData;
      end else if (regAddr == ADDR_FIFO_ALERT_LEVEL) begin
        nxt_state.fifo_alert_level = regWrData;
      end else if (regAddr == ADDR_TIMER_CLOCK_DIV) begin
        nxt_state.timerClk = regWrData;
      end
    end

    // Write-only and unmapped offsets read zero
    if (regRdEn) begin
      if (regAddr == ADDR_CRC_PRESET_HIGH) begin
        nxt_state.rdData = state_ff.crcPresetHigh;
      end else if (regAddr == ADDR_FIXED_PRESET_A) begin
        nxt_state.rdData = state_ff.fixedPresetA;
      end else if (regAddr == ADDR_TEST_OUTPUT_SEL) begin
        nxt_state.rdData = state_ff.testSel;
      end else if (regAddr == ADDR_FIFO_ALERT_LEVEL) begin
        nxt_state.rdData = state_ff.fifo_alert_level;
      end else if (regAddr == ADDR_TIMER_CLOCK_DIV) begin
        nxt_state.rdData = state_ff.timerClk;
      end else begin
        nxt_state.rdData = 8'h00;
      end
    end

    // ********************
    // CRC preset
    // ********************
    if (events.crcStart && crcEnable) begin
      if (crcShortWidth) begin
        nxt_state.crc = {8'h00, crcPresetLow};
      end else begin
        nxt_state.crc = {state_ff.crcPresetHigh, crcPresetLow};
      end
    end

    // ********************
    // Test output routing
    // ********************
    case (rfcfg_sel_t'(state_ff.testSel[2:0]))
      RFCFG_SEL_LOW:        nxt_state.pin = 1'b0;
      RFCFG_SEL_HIGH:       nxt_state.pin = 1'b1;
      RFCFG_SEL_ENVELOPE:   nxt_state.pin = taps.envelope;
      RFCFG_SEL_SERIAL:     nxt_state.pin = taps.serialData;
      RFCFG_SEL_CARRIER:    nxt_state.pin = taps.carrierDemod;
      RFCFG_SEL_SUBCARRIER: nxt_state.pin = taps.subcarrierDemod;
      default:              nxt_state.pin = 1'b0;
    endcase

    // ********************
    // FIFO alerts
    // ********************
    // Free space is depth minus fill; a fill above the depth never occurs
    nxt_state.high_fill_alert = ((FIFO_DEPTH - fifoCount) <= {1'b0, state_ff.fifo_alert_level[5:0]});
    nxt_state.low_fill_alert = (fifoCount <= {1'b0, state_ff.fifo_alert_level[5:0]});

    // ********************
    // Timer
    // ********************
    nxt_state.expired = 1'b0;
    if (events.timerStart) begin
      // A zero start value never launches the timer
      nxt_state.running  = (timerStartValue != 8'h00);
      nxt_state.count    = timerStartValue;
      nxt_state.prescale = '0;
    end else if (events.timerStop) begin
      nxt_state.running = 1'b0;
    end else if (state_ff.running && tick) begin
      if (state_ff.count > 8'h01) begin
        nxt_state.count = state_ff.count - 8'h01;
      end else if (state_ff.timerClk[AUTO_RELOAD_BIT] && timerStartValue != 8'h00) begin
        nxt_state.count = timerStartValue;
      end else begin
        nxt_state.count   = 8'h00;
        nxt_state.running = 1'b0;
        nxt_state.expired = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff               <= '0;
      state_ff.crcPresetHigh <= RST_CRC_PRESET_HIGH;
      state_ff.fixedPresetA  <= RST_FIXED_PRESET_A;
      state_ff.testSel       <= RST_TEST_OUTPUT_SEL;
      state_ff.fifo_alert_level     <= RST_FIFO_ALERT_LEVEL;
      state_ff.timerClk      <= RST_TIMER_CLOCK_DIV;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign regRdData        = state_ff.rdData;
  assign testOutputPin    = state_ff.pin;
  assign highFillAlert    = state_ff.high_fill_alert;
  assign lowFillAlert     = state_ff.low_fill_alert;
  assign crcRegister      = state_ff.crc;
  assign timerRunning     = state_ff.running;
  assign timerValue       = state_ff.count;
  assign timerExpiredFlag = state_ff.expired;

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_crc_load;
    events.crcStart && crcEnable && !crcShortWidth
      |=> crcRegister[15:8] == $past(state_ff.crcPresetHigh);
  endproperty
  a_crc_load: assert property (p_crc_load) else $error("CRC high not preset");

  property p_crc_short;
    events.crcStart && crcEnable && crcShortWidth |=> crcRegister[15:8] == 8'h00;
  endproperty
  a_crc_short: assert property (p_crc_short) else $error("High byte used in short CRC");

  property p_sel_fixed;
    state_ff.testSel[2:1] == 2'b00 |=> testOutputPin == $past(state_ff.testSel[0]);
  endproperty
  a_sel_fixed: assert property (p_sel_fixed) else $error("Fixed pin level wrong");

  property p_sel_env;
    state_ff.testSel[2:0] == 3'b010 |=> testOutputPin == $past(taps.envelope);
  endproperty
  a_sel_env: assert property (p_sel_env) else $error("Envelope not routed");

  property p_sel_sub;
    state_ff.testSel[2:0] == 3'b101 |=> testOutputPin == $past(taps.subcarrierDemod);
  endproperty
  a_sel_sub: assert property (p_sel_sub) else $error("Subcarrier not routed");

  property p_sel_rsvd;
    state_ff.testSel[2:1] == 2'b11 |=> !testOutputPin;
  endproperty
  a_sel_rsvd: assert property (p_sel_rsvd) else $error("Reserved code drives pin");

  property p_lo_alert;
    fifoCount <= {1'b0, state_ff.fifo_alert_level[5:0]} |=> lowFillAlert;
  endproperty
  a_lo_alert: assert property (p_lo_alert) else $error("Low alert missing");

  property p_hi_alert;
    fifoCount == FIFO_DEPTH |=> highFillAlert;
  endproperty
  a_hi_alert: assert property (p_hi_alert) else $error("High alert missing");

  property p_zero_start;
    events.timerStart && timerStartValue == 8'h00 |=> !timerRunning;
  endproperty
  a_zero_start: assert property (p_zero_start) else $error("Zero value started timer");

  // A zero start value under auto reload still ends with an expiry pulse
  property p_expire;
    timerExpiredFlag |-> !timerRunning && timerValue == 8'h00 &&
      !($past(state_ff.timerClk[AUTO_RELOAD_BIT]) && $past(timerStartValue) != 8'h00);
  endproperty
  a_expire: assert property (p_expire) else $error("Expiry with auto reload");

  property p_reload;
    timerRunning && state_ff.timerClk[AUTO_RELOAD_BIT] && !events.timerStop && timerStartValue != 8'h00
      |=> timerRunning;
  endproperty
  a_reload: assert property (p_reload) else $error("Auto reload timer stopped");

  // ********************
  // Routing, CRC and alert checks
  // ********************
  // Demodulator taps only carry meaning for type A traffic at 106 kBd
  property p_sel_serial;
    rfcfg_sel_t'(state_ff.testSel[2:0]) == RFCFG_SEL_SERIAL |=> testOutputPin == $past(taps.serialData);
  endproperty
  a_sel_serial: assert property (p_sel_serial) else $error("Serial data not routed");

  property p_sel_carrier;
    rfcfg_sel_t'(state_ff.testSel[2:0]) == RFCFG_SEL_CARRIER |=> testOutputPin == $past(taps.carrierDemod);
  endproperty
  a_sel_carrier: assert property (p_sel_carrier) else $error("Carrier not routed");

  property p_crc_low;
    events.crcStart && crcEnable |=> crcRegister[7:0] == $past(crcPresetLow);
  endproperty
  a_crc_low: assert property (p_crc_low) else $error("CRC low byte not preset");

  // The CRC register only moves on an enabled start event
  property p_crc_hold;
    !(events.crcStart && crcEnable) |=> $stable(crcRegister);
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("CRC moved without start");

  // An empty FIFO has more free space than any six-bit level
  property p_hi_clear;
    fifoCount == 7'h00 |=> !highFillAlert;
  endproperty
  a_hi_clear: assert property (p_hi_clear) else $error("High alert on empty FIFO");

  // A full FIFO holds more bytes than any six-bit level
  property p_lo_clear;
    fifoCount == FIFO_DEPTH |=> !lowFillAlert;
  endproperty
  a_lo_clear: assert property (p_lo_clear) else $error("Low alert on full FIFO");

  // ********************
  // Timer checks
  // ********************
  property p_start_load;
    events.timerStart |=> timerValue == $past(timerStartValue);
  endproperty
  a_start_load: assert property (p_start_load) else $error("Start value not loaded");

  property p_start_run;
    events.timerStart && timerStartValue != 8'h00 |=> timerRunning;
  endproperty
  a_start_run: assert property (p_start_run) else $error("Timer did not start");

  // Exponent zero ticks on every clock
  property p_tick_rate;
    timerRunning && state_ff.timerClk[4:0] == 5'h00 && timerValue > 8'h01 &&
      !events.timerStart && !events.timerStop |=> timerValue == $past(timerValue) - 8'h01;
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("Timer missed a tick");

  property p_expire_pulse;
    timerExpiredFlag |=> !timerExpiredFlag;
  endproperty
  a_expire_pulse: assert property (p_expire_pulse) else $error("Expiry pulse too long");

  // ********************
  // Register port checks
  // ********************
  property p_reset_values;
    $fell(rst) |-> state_ff.crcPresetHigh == RST_CRC_PRESET_HIGH &&
      state_ff.testSel == RST_TEST_OUTPUT_SEL && state_ff.fifo_alert_level == RST_FIFO_ALERT_LEVEL &&
      state_ff.timerClk == RST_TIMER_CLOCK_DIV && !testOutputPin;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("Wrong value after reset");

  // A written level reads back whole, spare bits included
  property p_level_readback;
    regWrEn && regAddr == ADDR_FIFO_ALERT_LEVEL ##1 !regWrEn ##1
      regRdEn && !regWrEn && regAddr == ADDR_FIFO_ALERT_LEVEL
      |=> regRdData == $past(regWrData, 3);
  endproperty
  a_level_readback: assert property (p_level_readback) else $error("Level readback wrong");

  // Write-only offsets answer zero
  property p_unmapped_read;
    regRdEn && regAddr == ADDR_FIXED_PRESET_B |=> regRdData == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("Write-only offset read nonzero");

  // ********************
  // Cover points
  // ********************
  c_expire: cover property (timerExpiredFlag);
  c_envelope: cover property (state_ff.testSel[2:0] == 3'b010 ##1 testOutputPin);
  c_hi_alert: cover property (highFillAlert && lowFillAlert == 1'b0);
  c_auto_reload: cover property (timerRunning && timerValue == 8'h01 ##1 timerValue > 8'h01);
  c_crc_short: cover property (events.crcStart && crcEnable && crcShortWidth);
endmodule
`default_nettype wire

// ===== verif/rfcfg_host.sv
// Host model: byte-wide register port master driven on the falling edge.
// Assumes the slice samples strobes at the rising edge of core_clk.
`timescale 1ns/100ps
`default_nettype none
module rfcfg_host (
  input  wire logic       core_clk,
  input  wire logic [7:0] regRdData,
  output logic            regWrEn,
  output logic            regRdEn,
  output logic      [5:0] regAddr,
  output logic      [7:0] regWrData
);
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 6'h00;
    regWrData = 8'h00;
  end
  // Released lines show the inverse so stale values cannot pass
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    if (a == 6'h25 && d != 8'h00) return;
    if (a == 6'h2A && d[4:0] > 5'h15) return;
    @(negedge core_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge core_clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge core_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge core_clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask
endmodule
`default_nettype wire

// ===== verif/rfcfg_slice_tb.sv
// Self-checking bench for the register slice.
// Assumes the host model drives the register port; engine inputs from here.
`timescale 1ns/100ps
`default_nettype none
module rfcfg_slice_tb;
  import rfcfg_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, regWrEn, regRdEn, crcEnable = 1'b0, crcShortWidth = 1'b0;
  logic [5:0] regAddr;
  logic [7:0] regWrData, regRdData, crcPresetLow = 8'h00, timerStartValue = 8'h00, rv, timerValue;
  logic [6:0] fifoCount = 7'h00;
  logic [15:0] crcRegister;
  logic testOutputPin, highFillAlert, lowFillAlert, timerRunning, timerExpiredFlag;
  rfcfg_taps_t taps = '0;
  rfcfg_events_t ev = '0;
  int n_fail = 0, cmp_count = 0, expCnt = 0, n, base;
  logic [5:0] ra [7] = '{6'h24, 6'h25, 6'h26, 6'h29, 6'h2A, 6'h27, 6'h28};
  logic [7:0] rx [7] = '{8'h63, 8'h00, 8'h00, 8'h08, 8'h07, 8'h00, 8'h00};
  logic [6:0] fc [5] = '{7'h14, 7'h15, 7'h2B, 7'h2C, 7'h40};
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (timerExpiredFlag === 1'b1) expCnt <= expCnt + 1;
  rfcfg_host i_rfcfg_host (.core_clk(core_clk), .regRdData(regRdData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData));
  rfcfg_slice i_rfcfg_slice (.core_clk(core_clk), .rst(rst), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .taps(taps), .events(ev), .crcEnable(crcEnable), .crcShortWidth(crcShortWidth),
    .crcPresetLow(crcPresetLow), .timerStartValue(timerStartValue), .fifoCount(fifoCount),
    .testOutputPin(testOutputPin), .highFillAlert(highFillAlert), .lowFillAlert(lowFillAlert),
    .crcRegister(crcRegister), .timerRunning(timerRunning), .timerValue(timerValue),
    .timerExpiredFlag(timerExpiredFlag));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pulse(input rfcfg_events_t m);
    @(negedge core_clk) ev = m;
    @(negedge core_clk) ev = '0;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Timer one-shot: duration is start value times two to the exponent
  task automatic oneShot(input logic [4:0] e, input logic [7:0] v);
    i_rfcfg_host.wr(6'h2A, {3'b110, e});
    timerStartValue = v;
    base = expCnt;
    pulse(3'b010);
    chk("timerValue", {8'h00, v}, {timerRunning ? 8'h00 : 8'hFF, timerValue});
    n = 0;
    while (timerRunning === 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 3000) begin
      n_fail++;
      print_verdict();
    end
    chk("duration", 1, n >= (v << e) - 1 && n <= (v << e) + 1);
    chk("timerExpiredFlag", 1, timerExpiredFlag);
    @(negedge core_clk);
    chk("expiry count", 1, 16'(expCnt - base));
  endtask
  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      i_rfcfg_host.rd(ra[i], rv);
      chk("reset value", rx[i], rv);
    end
    $display("test reset values done");
    for (int c = 0; c < 8; c++) begin
      i_rfcfg_host.wr(6'h26, {5'b00000, 3'(c)});
      for (int p = 0; p < 2; p++) begin
        @(negedge core_clk) taps = p ? 4'b0101 : 4'b1010;
        repeat (2) @(negedge core_clk);
        chk("testOutputPin", c == 1 || (c > 1 && c < 6 && taps[5 - c]), testOutputPin);
      end
    end
    i_rfcfg_host.wr(6'h26, 8'hF9);
    i_rfcfg_host.rd(6'h26, rv);
    chk("selector readback", 8'hF9, rv);
    $display("test selector done");
    i_rfcfg_host.wr(6'h29, 8'hD4);
    i_rfcfg_host.rd(6'h29, rv);
    chk("level readback", 8'hD4, rv);
    for (int i = 0; i < 5; i++) begin
      @(negedge core_clk) fifoCount = fc[i];
      repeat (2) @(negedge core_clk);
      chk("lowFillAlert", i == 0, lowFillAlert);
      chk("highFillAlert", i >= 3, highFillAlert);
    end
    $display("test alerts done");
    i_rfcfg_host.wr(6'h24, 8'hA5);
    crcPresetLow = 8'h3C;
    crcEnable = 1'b1;
    pulse(3'b100);
    chk("crcRegister", 16'hA53C, crcRegister);
    crcShortWidth = 1'b1;
    pulse(3'b100);
    chk("crcRegister", 16'h003C, crcRegister);
    crcShortWidth = 1'b0;
    crcEnable = 1'b0;
    pulse(3'b100);
    chk("crcRegister", 16'h003C, crcRegister);
    $display("test crc done");
    oneShot(5'h00, 8'h05);
    oneShot(5'h03, 8'h04);
    i_rfcfg_host.rd(6'h2A, rv);
    chk("divider readback", 8'hC3, rv);
    i_rfcfg_host.wr(6'h2A, 8'h20);
    timerStartValue = 8'h03;
    base = expCnt;
    pulse(3'b010);
    repeat (40) @(negedge core_clk);
    chk("timerRunning", 1, timerRunning);
    chk("expiry count", 0, 16'(expCnt - base));
    pulse(3'b001);
    timerStartValue = 8'h00;
    pulse(3'b010);
    chk("timerRunning", 0, timerRunning);
    $display("test timer done");
    print_verdict();
  end
endmodule
`default_nettype wire
